/* File: dmacc_regs.svh */
// register offsets, field positions and reset values of the dma channel block
// assumes byte addressing on a 32-bit ahb-lite slave, one aligned word per register
// Notes on behaviour
// - Clearing a channel's enable stops further transfers on that channel.
// - Setting the enable of a stopped channel lets its transfers carry on.
// - A per-channel pending flag shows a held request and must read 0 before disabling.
// - Sixteen-bit transfers never use an odd address; bit zero is forced to 0.
// - The engine wins the bus and a cpu access to a busy resource waits for the cycle end.
// - During external-to-peripheral transfers the cpu reaches internal ram at once.
// - During external-to-external transfers the cpu reaches ram and peripherals at once.
// - Finishing its programmed count sets the channel's completion flag to 1.
// - Four independent channels 0 to 3 each hold their own setup.
`ifndef DMACC_REGS_SVH
`define DMACC_REGS_SVH

// per-channel word offsets inside a 32-byte channel window
`define DMACC_OFF_SRC 8'h00
`define DMACC_OFF_DST 8'h04
`define DMACC_OFF_CNT 8'h08
`define DMACC_OFF_ADC 8'h0C
`define DMACC_OFF_TRG 8'h10
`define DMACC_OFF_CHC 8'h14
`define DMACC_CH_SHIFT 5
// global registers
`define DMACC_OFF_ISTAT 8'h80
`define DMACC_OFF_IMASK 8'h84

// addressing control fields
`define DMACC_ADC_W16 0
`define DMACC_ADC_SRC_LO 1
`define DMACC_ADC_DST_LO 3
`define DMACC_MODE_INC 2'h0
`define DMACC_MODE_DEC 2'h1
`define DMACC_MODE_FIX 2'h2
// trigger and channel control fields
`define DMACC_TRG_PEND 7
`define DMACC_CHC_EN 0
`define DMACC_CHC_TC 1
// region decode from address bits 29:28
`define DMACC_RGN_HI 29
`define DMACC_RGN_LO 28

// reset values
`define DMACC_RST_ADDR 32'h0000_0000
`define DMACC_RST_CNT 16'h0000
`define DMACC_RST_ADC 5'h00
`define DMACC_RST_TRG 6'h00

`endif

/* File: dmacc_pkg.sv */
// types shared by the dma channel control block
// assumes nothing beyond the register header
package dmacc_pkg;
    // gray codes along idle -> read -> write
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_READ = 2'b01,
        S_WRITE = 2'b11
    } dmacc_state_t;
    // target areas of a transfer
    typedef enum logic [1:0] {
        RG_EXT = 2'h0,
        RG_RAM = 2'h1,
        RG_PER = 2'h2,
        RG_NONE = 2'h3
    } dmacc_region_t;
endpackage

/* File: dmacc_top.sv */
// dma channel control, arbitration and cpu bus sharing, four channels
// assumes one clock, on-chip request sources and a memory port that acks in-domain
`timescale 1ns/1ps
`include "dmacc_regs.svh"
module dmacc_top #(
    parameter int NCH = 4,
    parameter int REQ_N = 64,
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // peripheral request lines
    input wire logic [REQ_N-1:0] periph_req,
    // transfer memory port
    output logic mem_req,
    output logic [31:0] mem_addr,
    output logic mem_write,
    output logic mem_half,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack,
    // cpu access arbitration
    input wire logic cpu_req,
    input wire logic [31:0] cpu_addr,
    output logic cpu_go,
    // interrupt
    output logic irq
);
    logic [31:0] src_q [NCH];
    logic [31:0] dst_q [NCH];
    logic [CNT_W-1:0] cnt_q [NCH];
    logic [4:0] adc_q [NCH];
    logic [5:0] trg_q [NCH];
    logic [NCH-1:0] en_q, tc_q, pend_q, ready, trig_hit;
    logic [REQ_N-1:0] req_prev_q;
    logic [NCH-1:0] istat_q, imask_q;
    dmacc_pkg::dmacc_state_t state_q;
    logic [1:0] act_q;
    logic wr_pend_q;
    logic [7:0] wr_off_q;
    logic [31:0] rdata_q, rd_d;
    logic mem_req_q, mem_write_q;
    logic [31:0] mem_addr_q;
    logic [15:0] mem_wdata_q;
    logic addr_ph, done;
    logic [31:0] wmask;

    // region of an address, shared by cpu and engine decode
    function automatic dmacc_pkg::dmacc_region_t rgn(input logic [31:0] a);
        rgn = dmacc_pkg::dmacc_region_t'(a[`DMACC_RGN_HI:`DMACC_RGN_LO]);
    endfunction

    // channel-relative offset, used by read and write decode
    function automatic logic [7:0] ch_off(input logic [7:0] a);
        ch_off = {3'h0, a[4:0]};
    endfunction

    // half-word transfers force address bit zero low
    function automatic logic [31:0] align(input logic [31:0] a, input logic w16);
        align = w16 ? {a[31:1], 1'b0} : a;
    endfunction

    // next address for the given mode
    function automatic logic [31:0] step(input logic [31:0] a, input logic [1:0] m,
                                         input logic w16);
        logic [31:0] s;
        s = w16 ? 32'h0000_0002 : 32'h0000_0001;
        unique case (m)
            `DMACC_MODE_INC: step = a + s;
            `DMACC_MODE_DEC: step = a - s;
            default: step = a;
        endcase
    endfunction

    // lowest index wins among ready channels
    function automatic logic [1:0] pick(input logic [NCH-1:0] r);
        pick = 2'h0;
        for (int i = NCH - 1; i >= 0; i--)
        begin
            if (r[i])
            begin
                pick = i[1:0];
            end
        end
    endfunction

    assign addr_ph = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;
    assign mem_req = mem_req_q;
    assign mem_addr = mem_addr_q;
    assign mem_write = mem_write_q;
    assign mem_half = adc_q[act_q][`DMACC_ADC_W16] && mem_req_q;
    assign mem_wdata = mem_wdata_q;
    assign done = (state_q == dmacc_pkg::S_WRITE) && mem_ack;
    assign irq = |(istat_q & imask_q);

    // per-channel readiness and trigger edges
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_ch
            assign trig_hit[g] = (int'(trg_q[g]) < REQ_N) && periph_req[trg_q[g]]
                                 && !req_prev_q[trg_q[g]];
            assign ready[g] = en_q[g] && pend_q[g] && (cnt_q[g] != '0);
        end
    endgenerate

    // request history for edge detection
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            req_prev_q <= '0;
        else
            req_prev_q <= periph_req;
    end

    // ahb address phase capture and registered read data
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_pend_q <= 1'b0;
            wr_off_q <= 8'h00;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_q <= addr_ph && hwrite;
            if (addr_ph)
                wr_off_q <= haddr[7:0];
            if (addr_ph && !hwrite)
                rdata_q <= rd_d;
        end
    end

    // read mux; unmapped offsets read zero
    always_comb
    begin
        logic [1:0] c;
        c = haddr[6:5];
        rd_d = 32'h0000_0000;
        if (haddr[7:0] == `DMACC_OFF_ISTAT)
            rd_d = {{(32-NCH){1'b0}}, istat_q};
        else if (haddr[7:0] == `DMACC_OFF_IMASK)
            rd_d = {{(32-NCH){1'b0}}, imask_q};
        else if (!haddr[7])
        begin
            unique case (ch_off(haddr[7:0]))
                `DMACC_OFF_SRC: rd_d = src_q[c];
                `DMACC_OFF_DST: rd_d = dst_q[c];
                `DMACC_OFF_CNT: rd_d = {{(32-CNT_W){1'b0}}, cnt_q[c]};
                `DMACC_OFF_ADC: rd_d = {27'h0, adc_q[c]};
                `DMACC_OFF_TRG: rd_d = {24'h0, pend_q[c], 1'b0, trg_q[c]};
                `DMACC_OFF_CHC: rd_d = {30'h0, tc_q[c], en_q[c]};
                default: rd_d = 32'h0000_0000;
            endcase
        end
    end

    // setup registers: bus writes only while disabled, engine updates after each cycle
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < NCH; i++)
            begin
                src_q[i] <= `DMACC_RST_ADDR;
                dst_q[i] <= `DMACC_RST_ADDR;
                cnt_q[i] <= `DMACC_RST_CNT;
                adc_q[i] <= `DMACC_RST_ADC;
                trg_q[i] <= `DMACC_RST_TRG;
            end
        end
        else
        begin
            if (wr_pend_q && !wr_off_q[7] && !en_q[wr_off_q[6:5]])
            begin
                unique case (ch_off(wr_off_q))
                    `DMACC_OFF_SRC: src_q[wr_off_q[6:5]] <= hwdata;
                    `DMACC_OFF_DST: dst_q[wr_off_q[6:5]] <= hwdata;
                    `DMACC_OFF_CNT: cnt_q[wr_off_q[6:5]] <= hwdata[CNT_W-1:0];
                    `DMACC_OFF_ADC: adc_q[wr_off_q[6:5]] <= hwdata[4:0];
                    `DMACC_OFF_TRG: trg_q[wr_off_q[6:5]] <= hwdata[5:0];
                    default: ;
                endcase
            end
            // pausing leaves these untouched until the next done
            if (done)
            begin
                src_q[act_q] <= step(src_q[act_q], adc_q[act_q][2:1], adc_q[act_q][0]);
                dst_q[act_q] <= step(dst_q[act_q], adc_q[act_q][4:3], adc_q[act_q][0]);
                cnt_q[act_q] <= cnt_q[act_q] - 1'b1;
            end
        end
    end

    // enable, completion and pending flags; hardware set beats software clear
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            en_q <= '0;
            tc_q <= '0;
            pend_q <= '0;
        end
        else
        begin
            for (int i = 0; i < NCH; i++)
            begin
                if (done && act_q == i[1:0])
                begin
                    pend_q[i] <= 1'b0;
                    if (cnt_q[i] == 1)
                        en_q[i] <= 1'b0;
                end
                if (trig_hit[i] && en_q[i])
                    pend_q[i] <= 1'b1;
                if (wr_pend_q && wr_off_q == ({1'b0, i[1:0], 5'h00} | `DMACC_OFF_CHC))
                begin
                    en_q[i] <= hwdata[`DMACC_CHC_EN];
                    if (hwdata[`DMACC_CHC_EN])
                        tc_q[i] <= 1'b0;
                end
                if (done && act_q == i[1:0] && cnt_q[i] == 1)
                    tc_q[i] <= 1'b1;
            end
        end
    end

    // interrupt status, cleared by reading; a new event in that cycle survives
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            istat_q <= '0;
            imask_q <= '0;
        end
        else
        begin
            logic [NCH-1:0] ev;
            ev = '0;
            if (done && cnt_q[act_q] == 1)
                ev[act_q] = 1'b1;
            if (addr_ph && !hwrite && haddr[7:0] == `DMACC_OFF_ISTAT)
                istat_q <= ev;
            else
                istat_q <= istat_q | ev;
            if (wr_pend_q && wr_off_q == `DMACC_OFF_IMASK)
                imask_q <= hwdata[NCH-1:0];
        end
    end

    // transfer engine: one read then one write per request
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= dmacc_pkg::S_IDLE;
            act_q <= 2'h0;
            mem_req_q <= 1'b0;
            mem_write_q <= 1'b0;
            mem_addr_q <= 32'h0000_0000;
            mem_wdata_q <= 16'h0000;
        end
        else
        begin
            unique case (state_q)
                dmacc_pkg::S_IDLE:
                begin
                    // disabled channels are never picked, so a pause waits for the cycle end
                    if (|ready)
                    begin
                        act_q <= pick(ready);
                        state_q <= dmacc_pkg::S_READ;
                        mem_req_q <= 1'b1;
                        mem_write_q <= 1'b0;
                        mem_addr_q <= align(src_q[pick(ready)], adc_q[pick(ready)][0]);
                    end
                end
                dmacc_pkg::S_READ:
                begin
                    if (mem_ack)
                    begin
                        state_q <= dmacc_pkg::S_WRITE;
                        mem_write_q <= 1'b1;
                        mem_wdata_q <= mem_rdata;
                        mem_addr_q <= align(dst_q[act_q], adc_q[act_q][0]);
                    end
                end
                dmacc_pkg::S_WRITE:
                begin
                    if (mem_ack)
                    begin
                        state_q <= dmacc_pkg::S_IDLE;
                        mem_req_q <= 1'b0;
                        mem_write_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    // cpu sharing: only the areas the running cycle touches are blocked
    always_comb
    begin
        dmacc_pkg::dmacc_region_t cr, sr, dr;
        cr = rgn(cpu_addr);
        sr = rgn(src_q[act_q]);
        dr = rgn(dst_q[act_q]);
        if (state_q == dmacc_pkg::S_IDLE)
            cpu_go = cpu_req;
        else
            cpu_go = cpu_req && cr != sr && cr != dr;
    end

    sequence s_start;
        state_q == dmacc_pkg::S_IDLE && |ready;
    endsequence
    sequence s_read_issued;
        state_q == dmacc_pkg::S_READ && mem_req && !mem_write;
    endsequence

    a_start_read: assert property (@(posedge core_clk) disable iff (!nrst)
        s_start |=> s_read_issued)
        else $error("ready channel did not start a read");
    a_pause_holds: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_q == dmacc_pkg::S_IDLE && ready == '0) |=> state_q == dmacc_pkg::S_IDLE)
        else $error("engine started with no enabled ready channel");
    a_pend_shows: assert property (@(posedge core_clk) disable iff (!nrst)
        (trig_hit[1] && en_q[1]) |=> pend_q[1])
        else $error("request edge not shown as pending");
    a_half_even: assert property (@(posedge core_clk) disable iff (!nrst)
        mem_half |-> !mem_addr[0])
        else $error("odd address on half-word transfer");
    a_cpu_blocked: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_q != dmacc_pkg::S_IDLE && rgn(cpu_addr) == rgn(src_q[act_q])) |-> !cpu_go)
        else $error("cpu granted a busy resource");
    a_ram_free: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_q != dmacc_pkg::S_IDLE && cpu_req && rgn(cpu_addr) == dmacc_pkg::RG_RAM
         && rgn(src_q[act_q]) != dmacc_pkg::RG_RAM && rgn(dst_q[act_q]) != dmacc_pkg::RG_RAM)
        |-> cpu_go)
        else $error("cpu held off internal ram");
    a_ext_ext_free: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_q != dmacc_pkg::S_IDLE && cpu_req && rgn(cpu_addr) != dmacc_pkg::RG_EXT
         && rgn(src_q[act_q]) == dmacc_pkg::RG_EXT && rgn(dst_q[act_q]) == dmacc_pkg::RG_EXT)
        |-> cpu_go)
        else $error("cpu held off during ext to ext transfer");
    a_tc_sets: assert property (@(posedge core_clk) disable iff (!nrst)
        (done && cnt_q[act_q] == 1) |=> tc_q[$past(act_q)] && !en_q[$past(act_q)])
        else $error("completion flag not set on last transfer");
    a_count_kept: assert property (@(posedge core_clk) disable iff (!nrst)
        (!(done && act_q == 2'h3) && !wr_pend_q) |=> $stable(cnt_q[3]) && $stable(src_q[3]))
        else $error("channel setup changed while paused");
    a_setup_locked: assert property (@(posedge core_clk) disable iff (!nrst)
        (en_q[1] && !(done && act_q == 2'h1)) |=> $stable(src_q[1]) && $stable(dst_q[1]))
        else $error("setup changed while channel enabled");
endmodule

/* File: dmacc_mem_model.sv */
// memory and peripheral model on the far side of the transfer port
// assumes one clock and an engine that holds mem_req until mem_ack
`timescale 1ns/1ps
module dmacc_mem_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // transfer port from the engine
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic mem_write,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata,
    output logic mem_ack,
    // bench control and write log
    input wire logic slow,
    output logic [31:0] wr_addr,
    output logic [15:0] wr_data
);
    logic [3:0] wait_q;
    // ack after 1 or 6 waiting cycles; read data good only in the ack cycle
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wait_q <= 4'h0;
            mem_ack <= 1'b0;
            mem_rdata <= 16'h0000;
        end
        else if (mem_req && !mem_ack && wait_q >= (slow ? 4'h6 : 4'h1))
        begin
            wait_q <= 4'h0;
            mem_ack <= 1'b1;
            mem_rdata <= mem_addr[15:0] ^ 16'h5A5A;
        end
        else
        begin
            wait_q <= (mem_req && !mem_ack) ? wait_q + 4'h1 : 4'h0;
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata; // released bus: inverted every cycle, so it never holds one value
        end
    end
    // log each completed write for the bench
    always_ff @(posedge core_clk)
    begin
        if (mem_ack && mem_write)
        begin
            wr_addr <= mem_addr;
            wr_data <= mem_wdata;
        end
    end
endmodule

/* File: dmacc_top_tb_top.sv */
// self-checking bench for the dma channel control block
// assumes the memory model and a zero-wait ahb-lite slave
`timescale 1ns/1ps
module dmacc_top_tb_top;
    logic core_clk, nrst, hsel, hwrite, mem_req, mem_write, mem_half, mem_ack;
    logic cpu_req, cpu_go, irq, hresp, slow;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, mem_addr, cpu_addr, wr_addr;
    logic [15:0] mem_wdata, mem_rdata, wr_data;
    logic [63:0] periph_req;
    wire hrdy;
    int miscompares = 0;
    int comparisons = 0;

    dmacc_top #(.NCH(4), .REQ_N(64), .CNT_W(16)) dmacc_top_inst (
        .core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata),
        .periph_req(periph_req), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_write(mem_write), .mem_half(mem_half), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .cpu_req(cpu_req),
        .cpu_addr(cpu_addr), .cpu_go(cpu_go), .irq(irq));
    dmacc_mem_model dmacc_mem_model_inst (
        .core_clk(core_clk), .nrst(nrst), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_write(mem_write), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack), .slow(slow), .wr_addr(wr_addr), .wr_data(wr_data));

    // free-running 50 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic report_and_stop();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // bounded wait for an edge with hready high; a hang ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end while (hrdy !== 1'b1 && n < 50);
        if (hrdy !== 1'b1)
        begin
            miscompares++;
            report_and_stop();
        end
    endtask

    // one single-word transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        bus(1'b1, a, d, v);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] v;
        bus(1'b0, a, 32'h0000_0000, v);
        chk(what, exp, v);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic setup(input int ch, input logic [31:0] s, d, c, m, t);
        wr(8'(ch * 32), s);
        wr(8'(ch * 32 + 4), d);
        wr(8'(ch * 32 + 8), c);
        wr(8'(ch * 32 + 12), m);
        wr(8'(ch * 32 + 16), t);
    endtask

    // one rising edge on a request line, then quiet again
    task automatic pulse(input int i);
        periph_req[i] <= 1'b1;
        @(posedge core_clk);
        periph_req[i] <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wait_req(input logic lvl);
        int n;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end while (mem_req !== lvl && n < 100);
        if (mem_req !== lvl)
        begin
            miscompares++;
            report_and_stop();
        end
    endtask

    // cpu_req stays up between calls; the caller lowers it
    task automatic cpu_chk(input logic [31:0] a, input logic exp);
        cpu_req <= 1'b1;
        cpu_addr <= a;
        @(posedge core_clk);
        chk("cpu_go", {31'h0, exp}, {31'h0, cpu_go});
    endtask

    // main sequence
    initial
    begin
        nrst = 1'b0;
        {hsel, hwrite, cpu_req, slow} = 4'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        {haddr, hwdata, cpu_addr} = {3{32'h0000_0000}};
        periph_req = 64'h0;
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            rd_chk(8'(c * 32), 32'h0, "src reset");
            rd_chk(8'(c * 32 + 20), 32'h0, "chc reset");
        end
        wr(8'h18, 32'hFFFF_FFFF);
        rd_chk(8'h18, 32'h0, "unmapped");
        cpu_chk(32'h0000_0040, 1'b1);
        cpu_req <= 1'b0;
        $display("reset test done");
        // 16-bit ext to peripheral, odd addresses, two requests
        wr(8'h00, 32'h0000_0500);
        setup(1, 32'h0000_1001, 32'h2000_0003, 32'h2, 32'h1, 32'h5);
        wr(8'h84, 32'h2);
        wr(8'h34, 32'h1);
        wr(8'h20, 32'h0000_FFF0);
        rd_chk(8'h20, 32'h0000_1001, "src locked");
        rd_chk(8'h00, 32'h0000_0500, "ch0 src");
        slow <= 1'b1;
        pulse(5);
        wait_req(1'b1);
        chk("rd addr", 32'h0000_1000, mem_addr);
        chk("half", 32'h1, {31'h0, mem_half});
        cpu_chk(32'h1000_0040, 1'b1);
        cpu_chk(32'h0000_0040, 1'b0);
        cpu_chk(32'h2000_0040, 1'b0);
        cpu_req <= 1'b0;
        wait_req(1'b0);
        chk("wr addr", 32'h2000_0002, wr_addr);
        chk("wr data", 32'h0000_4A5A, {16'h0, wr_data});
        slow <= 1'b0;
        pulse(5);
        wait_req(1'b1);
        chk("rd addr 2", 32'h0000_1002, mem_addr);
        wait_req(1'b0);
        chk("wr addr 2", 32'h2000_0004, wr_addr);
        @(posedge core_clk);
        chk("irq set", 32'h1, {31'h0, irq});
        rd_chk(8'h34, 32'h2, "chc done");
        rd_chk(8'h28, 32'h0, "cnt end");
        rd_chk(8'h80, 32'h2, "istat");
        rd_chk(8'h80, 32'h0, "istat clear");
        chk("irq clear", 32'h0, {31'h0, irq});
        $display("half-word test done");
        // byte ext to ext, slow memory, masked completion
        setup(2, 32'h0000_0100, 32'h0000_0200, 32'h1, 32'h0, 32'h7);
        wr(8'h54, 32'h1);
        slow <= 1'b1;
        pulse(7);
        wait_req(1'b1);
        chk("byte mode", 32'h0, {31'h0, mem_half});
        cpu_chk(32'h1000_0040, 1'b1);
        cpu_chk(32'h2000_0040, 1'b1);
        cpu_chk(32'h0000_0040, 1'b0);
        cpu_req <= 1'b0;
        wait_req(1'b0);
        chk("wr addr 3", 32'h0000_0200, wr_addr);
        chk("wr data 3", 32'h0000_5B5A, {16'h0, wr_data});
        @(posedge core_clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        rd_chk(8'h80, 32'h4, "istat 2");
        $display("ext to ext test done");
        // pause and resume on channel 3
        slow <= 1'b0;
        // source counts down, destination fixed, so both non-increment modes run
        setup(3, 32'h1000_0010, 32'h2000_0020, 32'h3, 32'h12, 32'h9);
        wr(8'h74, 32'h1);
        pulse(9);
        wait_req(1'b1);
        wait_req(1'b0);
        rd_chk(8'h70, 32'h9, "pending low");
        wr(8'h74, 32'h0);
        pulse(9);
        for (int i = 0; i < 10; i++)
        begin
            @(posedge core_clk);
            chk("paused", 32'h0, {31'h0, mem_req});
        end
        rd_chk(8'h68, 32'h2, "cnt kept");
        rd_chk(8'h60, 32'h1000_000F, "src kept");
        rd_chk(8'h64, 32'h2000_0020, "dst kept");
        wr(8'h74, 32'h1);
        pulse(9);
        wait_req(1'b1);
        chk("resume rd", 32'h1000_000F, mem_addr);
        wait_req(1'b0);
        chk("resume wr", 32'h2000_0020, wr_addr);
        $display("pause test done");
        report_and_stop();
    end
endmodule
